// ==== logic/ulpra_pkg.sv ====
// constants and state type for the ulpi register access block
package ulpra_pkg;
  localparam logic [1:0] ULPRA_CMD_IDLE = 2'h0;
  localparam logic [1:0] ULPRA_CMD_TX = 2'h1;
  localparam logic [1:0] ULPRA_CMD_WR = 2'h2;
  localparam logic [1:0] ULPRA_CMD_RD = 2'h3;
  localparam int ULPRA_CMD_OP_HI = 7;
  localparam int ULPRA_CMD_OP_LO = 6;
  localparam logic [5:0] ULPRA_EXT_ESC = 6'h2F;
  localparam logic [5:0] ULPRA_TX_NOPID = 6'h00;
  localparam logic [7:0] ULPRA_BUS_IDLE = 8'h00;
  localparam logic [7:0] ULPRA_REG_RESET = 8'h00;
  localparam int ULPRA_REG_COUNT = 256;

  typedef enum logic [3:0] {
    ULPRA_IDLE,
    ULPRA_WR_CMD,
    ULPRA_WR_ADDR,
    ULPRA_WR_DATA,
    ULPRA_WR_STOP,
    ULPRA_WR_COMMIT,
    ULPRA_RD_CMD,
    ULPRA_RD_ADDR,
    ULPRA_RD_TURN,
    ULPRA_RD_SEND,
    ULPRA_TX_BUSY,
    ULPRA_TX_END,
    ULPRA_RX_TURN,
    ULPRA_RX_SEND,
    ULPRA_REL_TURN
  } ulpra_state_e;
endpackage : ulpra_pkg

// ==== logic/ulpra_core.sv ====
// phy-side ulpi protocol block: command decode, register array, rx status bytes
`timescale 1ns/1ps
module ulpra_core
  import ulpra_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic core_clk, // ulpi clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [DATA_W-1:0] data_in, // bus level seen at the pins
  output logic [DATA_W-1:0] data_out, // value driven while owning the bus
  output logic data_oe_n, // low while the device drives the bus
  output logic dir, // bus direction, high when device owns the bus
  output logic nxt, // byte pacing towards the link
  input wire logic stp, // stop from the link
  input wire logic sync_mode, // high in synchronous mode, low in any async mode
  input wire logic [DATA_W-1:0] rx_status, // live status byte content
  input wire logic status_event, // pulse: status changed, a status byte is owed
  output logic tx_start, // pulse: usb transmit begins
  output logic tx_nopid, // transmit carries no identifier (held with tx_pid)
  output logic [3:0] tx_pid, // packet identifier of the last transmit
  output logic reg_wr_strobe, // pulse: register committed
  output logic [7:0] reg_wr_addr, // address of last committed write
  output logic [DATA_W-1:0] reg_wr_data // value of last committed write
);
  // the command layout only makes sense on an 8-bit bus
  if (DATA_W != 8) begin : g_width_check
    $error("ulpra_core: bus must be 8 bits wide");
  end

  logic [DATA_W-1:0] reg_file [ULPRA_REG_COUNT];
  ulpra_state_e state;
  ulpra_state_e next_state;
  logic [7:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic status_owed;

  function automatic logic is_ext(input logic [DATA_W-1:0] cmd);
    return cmd[5:0] == ULPRA_EXT_ESC;
  endfunction : is_ext

  wire [1:0] cmd_op = data_in[ULPRA_CMD_OP_HI:ULPRA_CMD_OP_LO];
  // a command is only looked at while we listen and not in a turnaround
  wire cmd_seen = (state == ULPRA_IDLE) && sync_mode &&
                  (data_in != ULPRA_BUS_IDLE);
  wire cmd_tx = cmd_seen && (cmd_op == ULPRA_CMD_TX);
  // op 01 with bits 5:4 clear carries an identifier unless the low six are all zero
  wire tx_has_pid = (data_in[5:4] == 2'h0) &&
                    (data_in[5:0] != ULPRA_TX_NOPID);
  // status waits whenever the link holds a command; link requests win
  wire rx_go = (state == ULPRA_IDLE) && sync_mode && status_owed && !cmd_seen;
  // a stretched stp only delays the commit, the byte is already held
  wire commit = (state == ULPRA_WR_COMMIT) && !stp;
  // bytes paced by nxt are taken in these states only
  wire ext_addr_take = (state == ULPRA_WR_ADDR) || (state == ULPRA_RD_ADDR);
  wire wr_data_take = (state == ULPRA_WR_DATA);
  wire status_taken = (state == ULPRA_RX_TURN);
  // drive decisions look at the state being entered so data_out is a plain flop
  wire send_rd = (next_state == ULPRA_RD_SEND);
  wire send_rx = (next_state == ULPRA_RX_SEND);

  // handshake outputs decode the state directly
  assign nxt = (state == ULPRA_WR_CMD) || (state == ULPRA_WR_ADDR) ||
               (state == ULPRA_WR_DATA) || (state == ULPRA_RD_CMD) ||
               (state == ULPRA_RD_ADDR);
  assign dir = (state == ULPRA_RD_TURN) || (state == ULPRA_RD_SEND) ||
               (state == ULPRA_RX_TURN) || (state == ULPRA_RX_SEND);

  always_comb begin
    next_state = state;
    case (state)
      ULPRA_IDLE: begin
        // a command beats an owed status byte in the same cycle
        if (cmd_seen) begin
          case (cmd_op)
            ULPRA_CMD_TX: next_state = ULPRA_TX_BUSY;
            ULPRA_CMD_WR: next_state = ULPRA_WR_CMD;
            ULPRA_CMD_RD: next_state = ULPRA_RD_CMD;
            default: next_state = ULPRA_IDLE;
          endcase
        end else if (rx_go) begin
          next_state = ULPRA_RX_TURN;
        end
      end
      ULPRA_WR_CMD: next_state = is_ext(addr) ? ULPRA_WR_ADDR : ULPRA_WR_DATA;
      ULPRA_WR_ADDR: next_state = ULPRA_WR_DATA;
      ULPRA_WR_DATA: next_state = ULPRA_WR_STOP;
      ULPRA_WR_STOP: next_state = stp ? ULPRA_WR_COMMIT : ULPRA_WR_STOP;
      ULPRA_WR_COMMIT: next_state = stp ? ULPRA_WR_COMMIT : ULPRA_IDLE;
      ULPRA_RD_CMD: next_state = is_ext(addr) ? ULPRA_RD_ADDR : ULPRA_RD_TURN;
      ULPRA_RD_ADDR: next_state = ULPRA_RD_TURN;
      ULPRA_RD_TURN: next_state = ULPRA_RD_SEND;
      ULPRA_RD_SEND: next_state = ULPRA_REL_TURN;
      ULPRA_TX_BUSY: next_state = stp ? ULPRA_TX_END : ULPRA_TX_BUSY;
      ULPRA_TX_END: next_state = stp ? ULPRA_TX_END : ULPRA_IDLE;
      ULPRA_RX_TURN: next_state = ULPRA_RX_SEND;
      ULPRA_RX_SEND: next_state = ULPRA_REL_TURN;
      ULPRA_REL_TURN: next_state = ULPRA_IDLE;
      default: next_state = ULPRA_IDLE;
    endcase
  end

  // dir and nxt decode this register, so they change on the edge itself
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ULPRA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // address: low six bits of the command, or the full byte after the escape
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr <= 8'h00;
    end else if (cmd_seen) begin
      addr <= {2'b00, data_in[5:0]};
    end else if (ext_addr_take) begin
      addr <= data_in;
    end
  end

  // write byte waits here until stp has come and gone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_data <= ULPRA_REG_RESET;
    end else if (wr_data_take) begin
      wr_data <= data_in;
    end
  end

  // array has no reset; only the commit path touches it, so async modes keep it
  always_ff @(posedge core_clk) begin
    if (commit) begin
      reg_file[addr] <= wr_data;
    end
  end

  // last commit stays visible for whatever consumes the register values
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_wr_strobe <= 1'b0;
      reg_wr_addr <= 8'h00;
      reg_wr_data <= ULPRA_REG_RESET;
    end else begin
      reg_wr_strobe <= commit;
      if (commit) begin
        reg_wr_addr <= addr;
        reg_wr_data <= wr_data;
      end
    end
  end

  // set wins over clear so an event in the rx turnaround cycle is not lost
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_owed <= 1'b0;
    end else if (status_event) begin
      status_owed <= 1'b1;
    end else if (status_taken) begin
      status_owed <= 1'b0;
    end
  end

  // bus drive is registered; enable follows the state being entered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_out <= ULPRA_BUS_IDLE;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= !(send_rd || send_rx);
      if (send_rd) begin
        data_out <= reg_file[addr];
      end else if (send_rx) begin
        data_out <= rx_status;
      end else begin
        data_out <= ULPRA_BUS_IDLE;
      end
    end
  end

  // only the command byte is decoded; the packet datapath is outside this block
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_start <= 1'b0;
      tx_nopid <= 1'b0;
      tx_pid <= 4'h0;
    end else begin
      tx_start <= cmd_tx;
      if (cmd_tx) begin
        tx_nopid <= !tx_has_pid;
        tx_pid <= tx_has_pid ? data_in[3:0] : 4'h0;
      end
    end
  end
endmodule : ulpra_core

// ==== bench/ulpra_monitor.sv ====
// port-level concurrent checks for the ulpi register access block
`timescale 1ns/1ps
module ulpra_monitor (
  input wire logic core_clk, // ulpi clock
  input wire logic rst, // sync reset
  input wire logic [7:0] data_in, // bus level
  input wire logic data_oe_n, // device drive enable
  input wire logic dir, // direction
  input wire logic nxt, // pacing
  input wire logic stp, // stop
  input wire logic sync_mode, // synchronous mode
  input wire logic tx_start, // transmit start
  input wire logic tx_nopid, // no identifier
  input wire logic [3:0] tx_pid, // identifier
  input wire logic reg_wr_strobe // commit pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  cmd_paced_a: assert property (
    sync_mode && !dir && !$past(dir) && !nxt && data_in[7] |=> nxt)
    else $error("command not paced");
  wr_dir_low_a: assert property (
    nxt && !$past(nxt) && data_in[7:6] == 2'b10 |-> !dir [*5])
    else $error("direction rose in write");
  imm_rd_a: assert property (
    nxt && !$past(nxt) && data_in[7:6] == 2'b11 && data_in[5:0] != 6'h2f
    |=> dir && !nxt && data_oe_n ##1 dir && !data_oe_n ##1 !dir && data_oe_n)
    else $error("immediate read sequence wrong");
  ext_rd_a: assert property (
    nxt && !$past(nxt) && data_in == 8'hef
    |=> nxt && !dir ##1 dir && !nxt && data_oe_n ##1 !data_oe_n ##1 !dir)
    else $error("extended read sequence wrong");
  commit_late_a: assert property (
    reg_wr_strobe |-> !$past(stp) && $past(stp, 2))
    else $error("commit before stop fell");
  send_own_a: assert property (
    !data_oe_n |-> dir && $past(dir))
    else $error("drive without owning bus");
  send_one_a: assert property (
    !data_oe_n |=> data_oe_n && !dir)
    else $error("send not single cycle");
  async_quiet_a: assert property (
    !sync_mode && !dir |=> !dir)
    else $error("bus taken in async mode");
  tx_pid_a: assert property (
    tx_start |-> tx_pid == $past(data_in[3:0]) && tx_nopid == ($past(data_in[5:0]) == 6'h00))
    else $error("bad identifier");
  cover property (!data_oe_n);
  cover property (reg_wr_strobe);
  cover property (tx_start && tx_nopid);
endmodule : ulpra_monitor
bind ulpra_core ulpra_monitor u_ulpra_monitor (.core_clk, .rst, .data_in, .data_oe_n, .dir,
  .nxt, .stp, .sync_mode, .tx_start, .tx_nopid, .tx_pid, .reg_wr_strobe);

// ==== bench/ulpra_link.sv ====
// link-side model driving the ulpi bus
`timescale 1ns/1ps
module ulpra_link (
  input wire logic core_clk, // ulpi clock
  input wire logic dir, // device owns bus
  input wire logic nxt, // device pacing
  input wire logic data_oe_n, // device drive enable
  input wire logic [7:0] data_out, // device byte
  output logic [7:0] data_in, // resolved wire level
  output logic stp // stop
);
  logic [7:0] lnk = 8'h00;
  logic [7:0] last = 8'h00;
  logic dir_q = 1'b0;
  initial stp = 1'b0;
  // undriven bus shows inverse of last level so stale data never passes
  assign data_in = !data_oe_n ? data_out : (dir || dir_q) ? ~last : lnk;
  always @(posedge core_clk) begin
    last <= data_in;
    dir_q <= dir;
  end
  task automatic send(input logic [7:0] b);
    @(negedge core_clk);
    // the bus stays idle for one cycle after a release turnaround
    while (dir || dir_q) @(negedge core_clk);
    @(posedge core_clk);
    lnk <= b;
  endtask : send
  task automatic pace(input logic [7:0] b);
    @(negedge core_clk);
    while (!nxt) @(negedge core_clk);
    @(posedge core_clk);
    lnk <= b;
  endtask : pace
  task automatic wr(input logic ext, input logic [7:0] a, input logic [7:0] d);
    send({2'b10, ext ? 6'h2f : a[5:0]});
    if (ext) pace(a);
    pace(d);
    @(posedge core_clk);
    lnk <= 8'h00;
    stp <= 1'b1;
    @(posedge core_clk);
    stp <= 1'b0;
  endtask : wr
  task automatic grab(output logic [7:0] q);
    @(negedge core_clk);
    while (data_oe_n) @(negedge core_clk);
    q = data_in;
  endtask : grab
  task automatic rd(input logic ext, input logic [7:0] a, output logic [7:0] q);
    send({2'b11, ext ? 6'h2f : a[5:0]});
    pace(ext ? a : 8'h00);
    if (ext) pace(8'h00);
    grab(q);
  endtask : rd
  task automatic tx(input logic [7:0] c);
    send(c);
    @(posedge core_clk);
    lnk <= 8'h00;
    repeat (3) @(posedge core_clk);
    stp <= 1'b1;
    @(posedge core_clk);
    stp <= 1'b0;
  endtask : tx
endmodule : ulpra_link

// ==== bench/tb.sv ====
// self-checking bench for the ulpi register access block
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sync_mode = 1'b1;
  logic [7:0] rx_status = 8'h00;
  logic status_event = 1'b0;
  logic [7:0] data_in, data_out, reg_wr_addr, reg_wr_data, q;
  logic data_oe_n, dir, nxt, stp, tx_start, tx_nopid, reg_wr_strobe;
  logic [3:0] tx_pid;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  always #4 core_clk = ~core_clk;
  ulpra_core u_ulpra_core (.core_clk, .rst, .data_in, .data_out, .data_oe_n, .dir, .nxt, .stp,
    .sync_mode, .rx_status, .status_event, .tx_start, .tx_nopid, .tx_pid, .reg_wr_strobe,
    .reg_wr_addr, .reg_wr_data);
  ulpra_link u_ulpra_link (.core_clk, .dir, .nxt, .data_oe_n, .data_out, .data_in, .stp);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      close_out();
    end
  end
  // write, then check the commit pulse lands two cycles after stop
  task automatic wchk(input logic ext, input logic [7:0] a, input logic [7:0] d);
    u_ulpra_link.wr(ext, a, d);
    repeat (2) @(negedge core_clk);
    chk(8'(reg_wr_strobe), 8'h01);
    chk(reg_wr_addr, a);
    chk(reg_wr_data, d);
  endtask : wchk
  task automatic t_imm();
    wchk(1'b0, 8'h05, 8'ha5);
    u_ulpra_link.rd(1'b0, 8'h05, q);
    chk(q, 8'ha5);
  endtask : t_imm
  task automatic t_ext();
    wchk(1'b1, 8'hc5, 8'h3c);
    wchk(1'b1, 8'h2f, 8'h77);
    u_ulpra_link.rd(1'b1, 8'hc5, q);
    chk(q, 8'h3c);
    u_ulpra_link.rd(1'b1, 8'h2f, q);
    chk(q, 8'h77);
    u_ulpra_link.rd(1'b0, 8'h05, q);
    chk(q, 8'ha5);
  endtask : t_ext
  task automatic t_async();
    @(posedge core_clk);
    sync_mode <= 1'b0;
    rx_status <= 8'h5a;
    status_event <= 1'b1;
    @(posedge core_clk);
    status_event <= 1'b0;
    repeat (8) @(negedge core_clk);
    chk(8'(dir), 8'h00);
    @(posedge core_clk);
    sync_mode <= 1'b1;
    u_ulpra_link.grab(q);
    chk(q, 8'h5a);
    u_ulpra_link.rd(1'b0, 8'h05, q);
    chk(q, 8'ha5);
  endtask : t_async
  task automatic t_tx();
    fork
      u_ulpra_link.tx(8'h4a);
      begin
        // raise the status event once the transmit is under way
        wait (data_in == 8'h4a);
        @(posedge core_clk);
        status_event <= 1'b1;
        @(negedge core_clk);
        chk(8'(tx_start), 8'h01);
        @(posedge core_clk);
        status_event <= 1'b0;
        rx_status <= 8'hc3;
        @(negedge core_clk);
        chk(8'(dir), 8'h00);
      end
    join
    u_ulpra_link.grab(q);
    chk(q, 8'hc3);
    chk({tx_nopid, 3'h0, tx_pid}, 8'h0a);
    u_ulpra_link.tx(8'h40);
    @(negedge core_clk);
    chk({tx_nopid, 3'h0, tx_pid}, 8'h80);
  endtask : t_tx
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_imm();
    t_ext();
    t_async();
    t_tx();
    close_out();
  end
endmodule : tb
